/* File: design/pin_function_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_function_mux
   import port_af_pkg::*;
#(
   parameter int unsigned PINS  = 16,
   parameter int unsigned FUNCS = 16
) (
   input  wire logic                       i_clock,
   input  wire logic                       i_srst,
   input  wire logic [PINS*SEL_WIDTH-1:0]  i_sel,
   input  wire logic [PINS-1:0]            i_alt_en,
   input  wire logic [PINS-1:0]            i_latch,
   input  wire logic [FUNCS*PINS-1:0]      i_af_out,
   input  wire logic [PINS-1:0]            i_pin_in,
   output logic      [PINS-1:0]            o_pin_out,
   output logic      [FUNCS*PINS-1:0]      o_af_in
);

   for (genvar y = 0; y < PINS; y++) begin : g_pin
      logic [SEL_WIDTH-1:0] sel;
      assign sel = i_sel[y*SEL_WIDTH +: SEL_WIDTH];

      // every code reaches a function, none is reserved
      always_ff @(posedge i_clock) begin
         if (i_srst) begin
            o_pin_out[y] <= 1'b0;
         end else if (i_alt_en[y]) begin
            o_pin_out[y] <= i_af_out[32'(sel) * PINS + y];
         end else begin
            o_pin_out[y] <= i_latch[y];
         end
      end

      for (genvar n = 0; n < FUNCS; n++) begin : g_func
         always_ff @(posedge i_clock) begin
            if (i_srst) begin
               o_af_in[n*PINS + y] <= 1'b0;
            end else begin
               o_af_in[n*PINS + y] <= i_alt_en[y] && (32'(sel) == n) && i_pin_in[y];
            end
         end
      end

      alt_route_a: assert property (@(posedge i_clock) disable iff (i_srst)
         i_alt_en[y] |=> o_pin_out[y] == $past(i_af_out[32'(sel) * PINS + y]))
         else $error("alternate function not routed to pin");

      latch_route_a: assert property (@(posedge i_clock) disable iff (i_srst)
         !i_alt_en[y] |=> o_pin_out[y] == $past(i_latch[y]) && o_af_in[y] == 1'b0)
         else $error("selector leaked into non-alternate pin");
   end

endmodule : pin_function_mux
`default_nettype wire

/* File: design/port_af_pkg.sv */
package port_af_pkg;

   localparam int unsigned PIN_COUNT      = 16;
   localparam int unsigned FUNC_COUNT     = 16;
   localparam int unsigned SEL_WIDTH      = 4;
   localparam int unsigned ADDR_WIDTH     = 8;

   localparam logic [7:0]  ALT_MODE_OFFSET    = 8'h00;
   localparam logic [7:0]  OUT_LATCH_OFFSET   = 8'h14;
   localparam logic [7:0]  SEL_LOW_OFFSET     = 8'h20;
   localparam logic [7:0]  SEL_HIGH_OFFSET    = 8'h24;
   localparam logic [7:0]  BIT_CLEAR_OFFSET   = 8'h28;

   localparam logic [31:0] SEL_LOW_RESET      = 32'h0000_0000;
   localparam logic [31:0] SEL_HIGH_RESET     = 32'h0000_0000;
   localparam logic [15:0] ALT_MODE_RESET     = 16'h0000;
   localparam logic [15:0] OUT_LATCH_RESET    = 16'h0000;
   localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

   typedef struct packed {
      logic [7:0]  paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } apb_req_s;

endpackage : port_af_pkg

/* File: design/port_alt_function_and_bit_clear.sv */
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - low selector register, four bits per pin 0 to 7, read/write, resets zero.
// - high selector register, four bits per pin 8 to 15, resets zero.
// - selector value n connects the pin to alternate function n; all codes valid.
// - writing one to clear bit y clears output latch bit y; zero leaves it.
// - bit-clear register always reads as zero.
// - only low sixteen clear bits act; upper half writes do nothing.
module port_alt_function_and_bit_clear
   import port_af_pkg::*;
#(
   parameter int unsigned PINS  = PIN_COUNT,
   parameter int unsigned FUNCS = FUNC_COUNT
) (
   input  wire logic                  i_clock,
   input  wire logic                  i_srst,
   input  wire apb_req_s              i_apb,
   output logic                       o_pready,
   output logic      [31:0]           o_prdata,
   output logic                       o_pslverr,
   input  wire logic [FUNCS*PINS-1:0] i_af_out,
   input  wire logic [PINS-1:0]       i_pin_in,
   output logic      [PINS-1:0]       o_pin_out,
   output logic      [FUNCS*PINS-1:0] o_af_in,
   output logic      [PINS-1:0]       o_output_latch
);

   logic [31:0] sel_low_q;
   logic [31:0] sel_high_q;
   logic [15:0] alt_mode_q;
   logic [15:0] latch_q;
   logic        setup;
   logic        commit;
   logic        wr;
   logic        mapped;

   assign setup  = i_apb.psel && !i_apb.penable;
   assign commit = i_apb.psel && i_apb.penable && o_pready;
   assign wr     = commit && i_apb.pwrite;
   assign mapped = i_apb.paddr inside {ALT_MODE_OFFSET, OUT_LATCH_OFFSET, SEL_LOW_OFFSET,
                                       SEL_HIGH_OFFSET, BIT_CLEAR_OFFSET};

   // answer in the first access cycle, no wait states
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_pready <= 1'b0;
      end else begin
         o_pready <= setup;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_pslverr <= 1'b0;
      end else begin
         o_pslverr <= setup && !mapped;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_prdata <= READ_ZERO;
      end else if (setup && !i_apb.pwrite) begin
         unique case (i_apb.paddr)
            ALT_MODE_OFFSET:  o_prdata <= {16'h0000, alt_mode_q};
            OUT_LATCH_OFFSET: o_prdata <= {16'h0000, latch_q};
            SEL_LOW_OFFSET:   o_prdata <= sel_low_q;
            SEL_HIGH_OFFSET:  o_prdata <= sel_high_q;
            BIT_CLEAR_OFFSET: o_prdata <= READ_ZERO;
            default:          o_prdata <= READ_ZERO;
         endcase
      end else begin
         o_prdata <= READ_ZERO;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         sel_low_q <= SEL_LOW_RESET;
      end else if (wr && i_apb.paddr == SEL_LOW_OFFSET) begin
         sel_low_q <= i_apb.pwdata;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         sel_high_q <= SEL_HIGH_RESET;
      end else if (wr && i_apb.paddr == SEL_HIGH_OFFSET) begin
         sel_high_q <= i_apb.pwdata;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         alt_mode_q <= ALT_MODE_RESET;
      end else if (wr && i_apb.paddr == ALT_MODE_OFFSET) begin
         alt_mode_q <= i_apb.pwdata[15:0];
      end
   end

   // clear acts only on the write strobe; nothing of it is stored
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         latch_q <= OUT_LATCH_RESET;
      end else if (wr && i_apb.paddr == OUT_LATCH_OFFSET) begin
         latch_q <= i_apb.pwdata[15:0];
      end else if (wr && i_apb.paddr == BIT_CLEAR_OFFSET) begin
         latch_q <= latch_q & ~i_apb.pwdata[15:0];
      end
   end

   assign o_output_latch = latch_q[PINS-1:0];

   pin_function_mux #(
      .PINS  (PINS),
      .FUNCS (FUNCS)
   ) u_mux (
      .i_clock  (i_clock),
      .i_srst   (i_srst),
      .i_sel    ({sel_high_q, sel_low_q}),
      .i_alt_en (alt_mode_q[PINS-1:0]),
      .i_latch  (latch_q[PINS-1:0]),
      .i_af_out (i_af_out),
      .i_pin_in (i_pin_in),
      .o_pin_out(o_pin_out),
      .o_af_in  (o_af_in)
   );

   sel_low_write_a: assert property (@(posedge i_clock) disable iff (i_srst)
      wr && i_apb.paddr == SEL_LOW_OFFSET |=> sel_low_q == $past(i_apb.pwdata))
      else $error("low selector not written");

   sel_high_write_a: assert property (@(posedge i_clock) disable iff (i_srst)
      wr && i_apb.paddr == SEL_HIGH_OFFSET |=> sel_high_q == $past(i_apb.pwdata))
      else $error("high selector not written");

   bit_clear_a: assert property (@(posedge i_clock) disable iff (i_srst)
      wr && i_apb.paddr == BIT_CLEAR_OFFSET
      |=> latch_q == ($past(latch_q) & ~$past(i_apb.pwdata[15:0])))
      else $error("bit clear wrong");

   clear_upper_a: assert property (@(posedge i_clock) disable iff (i_srst)
      wr && i_apb.paddr == BIT_CLEAR_OFFSET && i_apb.pwdata[15:0] == 16'h0000
      |=> $stable(latch_q) && $stable(sel_low_q) && $stable(sel_high_q))
      else $error("upper clear half had an effect");

   clear_read_a: assert property (@(posedge i_clock) disable iff (i_srst)
      setup && !i_apb.pwrite && i_apb.paddr == BIT_CLEAR_OFFSET ##1 commit
      |-> o_prdata == READ_ZERO)
      else $error("bit clear read not zero");

   // ready follows setup by one edge; the master's penable drops it again
   pready_answer_a: assert property (@(posedge i_clock) disable iff (i_srst)
      setup |=> o_pready)
      else $error("no ready after setup");

   pready_pulse_a: assert property (@(posedge i_clock) disable iff (i_srst)
      o_pready |=> !o_pready)
      else $error("ready held for two cycles");

   slave_error_a: assert property (@(posedge i_clock) disable iff (i_srst)
      setup |=> o_pslverr != $past(mapped))
      else $error("error flag disagrees with address map");

   error_ready_a: assert property (@(posedge i_clock) disable iff (i_srst)
      o_pslverr |-> o_pready)
      else $error("error flag without ready");

   // read data stays zero outside a read answer so the bus mux can OR slaves
   read_idle_a: assert property (@(posedge i_clock) disable iff (i_srst)
      !setup || i_apb.pwrite
      |=> o_prdata == READ_ZERO)
      else $error("read data not zero when idle");

   sel_low_read_a: assert property (@(posedge i_clock) disable iff (i_srst)
      setup && !i_apb.pwrite && i_apb.paddr == SEL_LOW_OFFSET
      |=> o_prdata == $past(sel_low_q))
      else $error("low selector read wrong");

   sel_high_read_a: assert property (@(posedge i_clock) disable iff (i_srst)
      setup && !i_apb.pwrite && i_apb.paddr == SEL_HIGH_OFFSET
      |=> o_prdata == $past(sel_high_q))
      else $error("high selector read wrong");

   latch_read_a: assert property (@(posedge i_clock) disable iff (i_srst)
      setup && !i_apb.pwrite && i_apb.paddr == OUT_LATCH_OFFSET
      |=> o_prdata == {16'h0000, $past(latch_q)})
      else $error("output latch read wrong");

   alt_read_a: assert property (@(posedge i_clock) disable iff (i_srst)
      setup && !i_apb.pwrite && i_apb.paddr == ALT_MODE_OFFSET
      |=> o_prdata == {16'h0000, $past(alt_mode_q)})
      else $error("mode register read wrong");

   alt_write_a: assert property (@(posedge i_clock) disable iff (i_srst)
      wr && i_apb.paddr == ALT_MODE_OFFSET
      |=> alt_mode_q == $past(i_apb.pwdata[15:0]))
      else $error("mode register not written");

   latch_write_a: assert property (@(posedge i_clock) disable iff (i_srst)
      wr && i_apb.paddr == OUT_LATCH_OFFSET
      |=> latch_q == $past(i_apb.pwdata[15:0]))
      else $error("output latch not written");

   // an unmapped write only raises the error; no register may move
   unmapped_write_a: assert property (@(posedge i_clock) disable iff (i_srst)
      wr && !mapped
      |=> $stable(latch_q) && $stable(alt_mode_q) && $stable(sel_low_q) && $stable(sel_high_q))
      else $error("unmapped write changed a register");

   sel_hold_a: assert property (@(posedge i_clock) disable iff (i_srst)
      !wr |=> $stable(sel_low_q) && $stable(sel_high_q))
      else $error("selector moved without a write");

   latch_hold_a: assert property (@(posedge i_clock) disable iff (i_srst)
      !wr |=> $stable(latch_q) && $stable(alt_mode_q))
      else $error("latch moved without a write");

   // no disable here: it must see the reset cycles themselves
   reset_values_a: assert property (@(posedge i_clock)
      i_srst |=> sel_low_q == SEL_LOW_RESET && sel_high_q == SEL_HIGH_RESET
         && alt_mode_q == ALT_MODE_RESET && latch_q == OUT_LATCH_RESET)
      else $error("registers not at reset value");

endmodule : port_alt_function_and_bit_clear
`default_nettype wire

/* File: dv/function_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module function_partner (
   output logic [255:0] o_af_out,
   output logic [15:0]  o_pin_in
);
   // one-hot per function so every selector code gives a distinct pin pattern
   for (genvar n = 0; n < 16; n++) begin : g_fn
      assign o_af_out[n*16 +: 16] = 16'h0001 << n;
   end
   assign o_pin_in = 16'hA5C3;
endmodule : function_partner
`default_nettype wire

/* File: dv/port_alt_function_and_bit_clear_test.sv */
`timescale 1ns/1ps
`default_nettype none
module port_alt_function_and_bit_clear_test
   import port_af_pkg::*;
;
   typedef struct packed {
      logic [7:0]  a;
      logic        w;
      logic [31:0] d;
      logic        e;
   } row_s;
   logic           i_clock = 0;
   logic           i_srst  = 1;
   apb_req_s       req     = '0;
   logic           pready, pslverr;
   logic [31:0]    prdata, r;
   logic           e;
   logic [255:0]   af_out, af_in, exp_af;
   logic [15:0]    pin_in, pin_out, latch;
   int             errors = 0;
   int             tests_run = 0;
   row_s           rows [13] = '{
      '{8'h20, 1'b0, 32'h0000_0000, 1'b0}, '{8'h24, 1'b0, 32'h0000_0000, 1'b0},
      '{8'h00, 1'b0, 32'h0000_0000, 1'b0}, '{8'h14, 1'b0, 32'h0000_0000, 1'b0},
      '{8'h20, 1'b1, 32'h7654_3210, 1'b0}, '{8'h20, 1'b0, 32'h7654_3210, 1'b0},
      '{8'h24, 1'b1, 32'hFEDC_BA98, 1'b0}, '{8'h24, 1'b0, 32'hFEDC_BA98, 1'b0},
      '{8'h28, 1'b1, 32'h0000_0000, 1'b0}, '{8'h28, 1'b0, 32'h0000_0000, 1'b0},
      '{8'h30, 1'b0, 32'h0000_0000, 1'b1}, '{8'h30, 1'b1, 32'hFFFF_FFFF, 1'b1},
      '{8'h20, 1'b0, 32'h7654_3210, 1'b0}};

   always #20 i_clock = ~i_clock;

   function_partner function_partner_i (.o_af_out(af_out), .o_pin_in(pin_in));
   port_alt_function_and_bit_clear port_alt_function_and_bit_clear_i (
      .i_clock(i_clock), .i_srst(i_srst), .i_apb(req), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .i_af_out(af_out), .i_pin_in(pin_in),
      .o_pin_out(pin_out), .o_af_in(af_in), .o_output_latch(latch));

   task wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up

   task chk(input logic [255:0] got, input logic [255:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // held until pready is sampled high; bounded wait
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      req.paddr <= a;
      req.pwrite <= w;
      req.pwdata <= d;
      req.psel <= 1;
      req.penable <= 0;
      @(posedge i_clock);
      req.penable <= 1;
      do begin
         @(posedge i_clock);
         k++;
      end while (pready !== 1'b1 && k < 20);
      r = prdata;
      e = pslverr;
      if (pready !== 1'b1) begin
         errors++;
         wrap_up();
      end
      req.psel <= 0;
      req.penable <= 0;
      @(posedge i_clock);
   endtask : apb

   task settle;
      repeat (2) @(posedge i_clock);
      #1;
   endtask : settle

   initial begin
      repeat (8) @(posedge i_clock);
      i_srst <= 0;
      @(posedge i_clock);
      #1;
      chk({pready, pslverr, prdata, pin_out, latch}, '0);
      chk(af_in, '0);
      @(posedge i_clock);
      foreach (rows[i]) begin
         apb(rows[i].a, rows[i].w, rows[i].d);
         if (!rows[i].w) begin
            chk({r, e}, {rows[i].d, rows[i].e});
         end else begin
            chk({r, e}, {READ_ZERO, rows[i].e});
         end
      end
      $display("register rows done");
      apb(8'h00, 1, 32'h0000_FFFF);
      for (int n = 0; n < 16; n++) begin
         apb(8'h20, 1, n * 32'h1111_1111);
         apb(8'h24, 1, n * 32'h1111_1111);
         settle();
         chk(pin_out, 16'h0001 << n);
         chk(af_in, 256'(pin_in) << (n * 16));
         @(posedge i_clock);
      end
      apb(SEL_LOW_OFFSET, 1'b1, 32'h7654_3210);
      apb(SEL_HIGH_OFFSET, 1'b1, 32'hFEDC_BA98);
      settle();
      exp_af = '0;
      for (int y = 0; y < 16; y++) begin
         exp_af[y * 16 + y] = pin_in[y];
      end
      chk(pin_out, 16'hFFFF);
      chk(af_in, exp_af);
      @(posedge i_clock);
      $display("function codes done");
      apb(8'h14, 1, 32'h0000_FFFF);
      apb(8'h00, 1, 32'h0000_0000);
      settle();
      chk(pin_out, 16'hFFFF);
      chk(af_in, 256'h0);
      @(posedge i_clock);
      apb(8'h28, 1, 32'hFFFF_0005);
      settle();
      chk(latch, 16'hFFFA);
      @(posedge i_clock);
      apb(8'h28, 1, 32'hFFFF_0000);
      settle();
      chk(latch, 16'hFFFA);
      @(posedge i_clock);
      apb(BIT_CLEAR_OFFSET, 1'b0, READ_ZERO);
      chk({r, e}, {READ_ZERO, 1'b0});
      apb(OUT_LATCH_OFFSET, 1'b0, READ_ZERO);
      chk(r, 32'h0000_FFFA);
      $display("bit clear done");
      i_srst <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_srst <= 1'b0;
      @(posedge i_clock);
      #1;
      chk({pready, pslverr, prdata, pin_out, latch}, '0);
      chk(af_in, '0);
      @(posedge i_clock);
      apb(SEL_LOW_OFFSET, 1'b0, READ_ZERO);
      chk(r, SEL_LOW_RESET);
      apb(SEL_HIGH_OFFSET, 1'b0, READ_ZERO);
      chk(r, SEL_HIGH_RESET);
      $display("mid-run reset done");
      wrap_up();
   end
endmodule : port_alt_function_and_bit_clear_test
`default_nettype wire
